// ===== logic/ddrsp_defines.vh
// Timing constants for the command spacing guard of a DDR2 controller
// Assumes a 10 MHz controller clock (100 ns period)
`ifndef DDRSP_DEFINES_VH
`define DDRSP_DEFINES_VH
`define DDRSP_CLK_PS 100000
`define DDRSP_ACT_TO_ACT_GAP_PS 10000
`define DDRSP_COLUMN_CMD_GAP_CK 8'h02
`define DDRSP_WRITE_RECOVERY_GAP_PS 15000
`define DDRSP_WRITE_TO_READ_GAP_400_PS 10000
`define DDRSP_WRITE_TO_READ_GAP_533_PS 7500
`define DDRSP_READ_TO_PRECHARGE_GAP_PS 7500
`define DDRSP_CLOCK_ENABLE_MIN_PULSE_CK 8'h03
`define DDRSP_SELFREFRESH_EXIT_EXTRA_PS 10000
`define DDRSP_SELFREFRESH_EXIT_READ_GAP_CK 8'hC8
`define DDRSP_PRECHARGE_PD_EXIT_GAP_CK 8'h02
`define DDRSP_ACTIVE_PD_FAST_EXIT_GAP_CK 8'h02
`define DDRSP_ACTIVE_PD_SLOW_EXIT_BASE_CK 8'h06
`define DDRSP_TERMINATION_PD_ENTRY_LATENCY_CK 8'h03
`define DDRSP_TERMINATION_PD_EXIT_LATENCY_CK 8'h08
`define DDRSP_MODE_LOAD_CYCLE_GAP_CK 8'h02
`define DDRSP_MODE_LOAD_TO_TERMINATION_UPDATE_PS 12000
`define DDRSP_CALIBRATION_DRIVE_OUTPUT_DELAY_PS 12000
`define DDRSP_CLOCK_HOLD_AFTER_ENABLE_DROP_CK 8'h02
`define DDRSP_WRITE_STROBE_ALIGNMENT_CK 8'h00
`define DDRSP_REFRESH_CYCLE_PS 105000
`define DDRSP_PRECHARGE_PERIOD_PS 15000
`define DDRSP_CMD_NOP 3'h0
`define DDRSP_CMD_ACT 3'h1
`define DDRSP_CMD_RD 3'h2
`define DDRSP_CMD_WR 3'h3
`define DDRSP_CMD_PRE 3'h4
`define DDRSP_CMD_MRS 3'h5
`define DDRSP_CMD_WRA 3'h6
`define DDRSP_CMD_REF 3'h7
`endif

// ===== logic/ddrsp_guard.v
// Command spacing guard that a DDR2 controller places before its command pins
// Assumes requests arrive on ref_clk; the memory clock equals ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "ddrsp_defines.vh"
module ddrsp_guard (
    input wire ref_clk,
    input wire rst_n,
    input wire req_valid,
    input wire [2:0] req_cmd,
    input wire [1:0] req_bank,
    input wire grade_533,
    input wire [2:0] additive_latency,
    input wire pd_req,
    input wire selfrefresh_req,
    input wire slow_exit,
    input wire term_req,
    output wire req_ready,
    output reg [2:0] mem_cmd,
    output reg [1:0] mem_bank,
    output reg mem_cke,
    output reg mem_odt,
    output reg mem_clk_en,
    output reg mem_dqs_start,
    output wire term_valid
);
    localparam [3:0] S_ACTIVE = 4'h1;
    localparam [3:0] S_PD = 4'h2;
    localparam [3:0] S_SR = 4'h4;
    localparam [3:0] S_TERM = 4'h8;

    // Picoseconds to clocks, rounded up, at least one
    function [7:0] ps_to_ck;
        input integer ps;
        integer n;
        begin
            n = (ps + `DDRSP_CLK_PS - 1) / `DDRSP_CLK_PS;
            if (n < 1) begin
                n = 1;
            end
            ps_to_ck = n[7:0];
        end
    endfunction

    // Clamp remaining count with a new minimum
    function [7:0] keep_max;
        input [7:0] cur;
        input [7:0] req;
        begin
            keep_max = (req > cur) ? req : cur;
        end
    endfunction

    localparam [7:0] ACT_CK = ps_to_ck(`DDRSP_ACT_TO_ACT_GAP_PS);
    localparam [7:0] COL_CK = `DDRSP_COLUMN_CMD_GAP_CK;
    localparam [7:0] DAL_CK = ps_to_ck(`DDRSP_WRITE_RECOVERY_GAP_PS) +
        ps_to_ck(`DDRSP_PRECHARGE_PERIOD_PS);
    localparam [7:0] WTR4_CK = ps_to_ck(`DDRSP_WRITE_TO_READ_GAP_400_PS);
    localparam [7:0] WTR5_CK = ps_to_ck(`DDRSP_WRITE_TO_READ_GAP_533_PS);
    localparam [7:0] RTP_CK = ps_to_ck(`DDRSP_READ_TO_PRECHARGE_GAP_PS);
    localparam [7:0] CKE_CK = `DDRSP_CLOCK_ENABLE_MIN_PULSE_CK;
    localparam [7:0] XSNR_CK = ps_to_ck(`DDRSP_REFRESH_CYCLE_PS +
        `DDRSP_SELFREFRESH_EXIT_EXTRA_PS);
    localparam [7:0] XSRD_CK = `DDRSP_SELFREFRESH_EXIT_READ_GAP_CK;
    localparam [7:0] XP_CK = `DDRSP_PRECHARGE_PD_EXIT_GAP_CK;
    localparam [7:0] XARD_CK = `DDRSP_ACTIVE_PD_FAST_EXIT_GAP_CK;
    localparam [7:0] XARDS_CK = `DDRSP_ACTIVE_PD_SLOW_EXIT_BASE_CK;
    localparam [7:0] ANPD_CK = `DDRSP_TERMINATION_PD_ENTRY_LATENCY_CK;
    localparam [7:0] AXPD_CK = `DDRSP_TERMINATION_PD_EXIT_LATENCY_CK;
    localparam [7:0] MRD_CK = `DDRSP_MODE_LOAD_CYCLE_GAP_CK;
    localparam [7:0] MOD_CK = ps_to_ck(`DDRSP_MODE_LOAD_TO_TERMINATION_UPDATE_PS);
    localparam [7:0] OIT_CK = ps_to_ck(`DDRSP_CALIBRATION_DRIVE_OUTPUT_DELAY_PS);
    localparam [7:0] HOLD_CK = `DDRSP_CLOCK_HOLD_AFTER_ENABLE_DROP_CK;

    reg rst_meta;
    reg rst_sync;
    reg [1:0] pd_meta;
    reg [1:0] pd_sync;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [7:0] act_cnt;
    reg [7:0] col_cnt;
    reg [7:0] rd_cnt;
    reg [7:0] nonrd_cnt;
    reg [7:0] pre_cnt;
    reg [7:0] cke_cnt;
    reg [7:0] term_cnt;
    reg [7:0] clk_cnt;
    reg [7:0] bank_cnt0;
    reg [7:0] bank_cnt1;
    reg [7:0] bank_cnt2;
    reg [7:0] bank_cnt3;
    reg [7:0] bank_cnt_sel;
    reg cmd_ok;
    wire is_rd;
    wire is_col;
    wire fire;
    wire want_pd;
    wire want_sr;
    wire [7:0] slow_ck;

    // Reset release through two flops
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Power requests treated as asynchronous pins
    always @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            pd_meta <= 2'h0;
            pd_sync <= 2'h0;
        end else begin
            pd_meta <= {selfrefresh_req, pd_req};
            pd_sync <= pd_meta;
        end
    end
    assign want_pd = pd_sync[0];
    assign want_sr = pd_sync[1];

    assign is_rd = (req_cmd == `DDRSP_CMD_RD);
    assign is_col = is_rd || (req_cmd == `DDRSP_CMD_WR) || (req_cmd == `DDRSP_CMD_WRA);
    assign slow_ck = (XARDS_CK > {5'h00, additive_latency} + 8'h01) ?
        XARDS_CK - {5'h00, additive_latency} : 8'h01;

    always @* begin
        case (req_bank)
            2'h0: bank_cnt_sel = bank_cnt0;
            2'h1: bank_cnt_sel = bank_cnt1;
            2'h2: bank_cnt_sel = bank_cnt2;
            default: bank_cnt_sel = bank_cnt3;
        endcase
    end

    always @* begin
        cmd_ok = (state == S_ACTIVE) && mem_cke;
        if (is_rd && rd_cnt != 8'h00) begin
            cmd_ok = 1'b0;
        end
        if (!is_rd && nonrd_cnt != 8'h00) begin
            cmd_ok = 1'b0;
        end
        if (is_col && col_cnt != 8'h00) begin
            cmd_ok = 1'b0;
        end
        if (req_cmd == `DDRSP_CMD_ACT && (act_cnt != 8'h00 || bank_cnt_sel != 8'h00)) begin
            cmd_ok = 1'b0;
        end
        if (req_cmd == `DDRSP_CMD_PRE && pre_cnt != 8'h00) begin
            cmd_ok = 1'b0;
        end
    end

    assign fire = req_valid && cmd_ok && !want_pd && !want_sr;
    assign req_ready = cmd_ok && !want_pd && !want_sr;
    assign term_valid = (term_cnt == 8'h00) && mem_cke;

    always @* begin
        next_state = state;
        case (state)
            S_ACTIVE: begin
                if ((want_pd || want_sr) && cke_cnt == 8'h00 && nonrd_cnt == 8'h00) begin
                    next_state = S_TERM;
                end
            end
            S_TERM: begin
                if (!want_pd && !want_sr) begin
                    next_state = S_ACTIVE;
                end else if (term_cnt == 8'h00) begin
                    next_state = want_sr ? S_SR : S_PD;
                end
            end
            S_PD: begin
                if (!want_pd && cke_cnt == 8'h00) begin
                    next_state = S_ACTIVE;
                end
            end
            S_SR: begin
                if (!want_sr && cke_cnt == 8'h00) begin
                    next_state = S_ACTIVE;
                end
            end
            default: next_state = S_ACTIVE;
        endcase
    end

    // Down-counters holding every spacing
    always @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= S_ACTIVE;
            act_cnt <= 8'h00;
            col_cnt <= 8'h00;
            rd_cnt <= 8'h00;
            nonrd_cnt <= 8'h00;
            pre_cnt <= 8'h00;
            cke_cnt <= CKE_CK;
            term_cnt <= 8'h00;
            clk_cnt <= 8'h00;
            bank_cnt0 <= 8'h00;
            bank_cnt1 <= 8'h00;
            bank_cnt2 <= 8'h00;
            bank_cnt3 <= 8'h00;
            mem_cmd <= `DDRSP_CMD_NOP;
            mem_bank <= 2'h0;
            mem_cke <= 1'b0;
            mem_odt <= 1'b0;
            mem_clk_en <= 1'b1;
            mem_dqs_start <= 1'b0;
        end else begin
            state <= next_state;
            act_cnt <= (act_cnt != 8'h00) ? act_cnt - 8'h01 : 8'h00;
            col_cnt <= (col_cnt != 8'h00) ? col_cnt - 8'h01 : 8'h00;
            rd_cnt <= (rd_cnt != 8'h00) ? rd_cnt - 8'h01 : 8'h00;
            nonrd_cnt <= (nonrd_cnt != 8'h00) ? nonrd_cnt - 8'h01 : 8'h00;
            pre_cnt <= (pre_cnt != 8'h00) ? pre_cnt - 8'h01 : 8'h00;
            cke_cnt <= (cke_cnt != 8'h00) ? cke_cnt - 8'h01 : 8'h00;
            term_cnt <= (term_cnt != 8'h00) ? term_cnt - 8'h01 : 8'h00;
            bank_cnt0 <= (bank_cnt0 != 8'h00) ? bank_cnt0 - 8'h01 : 8'h00;
            bank_cnt1 <= (bank_cnt1 != 8'h00) ? bank_cnt1 - 8'h01 : 8'h00;
            bank_cnt2 <= (bank_cnt2 != 8'h00) ? bank_cnt2 - 8'h01 : 8'h00;
            bank_cnt3 <= (bank_cnt3 != 8'h00) ? bank_cnt3 - 8'h01 : 8'h00;
            mem_cmd <= `DDRSP_CMD_NOP;
            mem_dqs_start <= 1'b0;
            mem_odt <= term_req;
            // Clock held running for a while after clock enable drops
            if (clk_cnt != 8'h00) begin
                clk_cnt <= clk_cnt - 8'h01;
            end else if (!mem_cke && state != S_ACTIVE) begin
                mem_clk_en <= 1'b0;
            end
            if (state == S_ACTIVE && mem_cke == 1'b0 && cke_cnt == 8'h00) begin
                mem_cke <= 1'b1;
                mem_clk_en <= 1'b1;
                cke_cnt <= CKE_CK;
                nonrd_cnt <= XP_CK;
                rd_cnt <= XP_CK;
            end
            if (fire) begin
                mem_cmd <= req_cmd;
                mem_bank <= req_bank;
                if (is_col) begin
                    col_cnt <= COL_CK - 8'h01;
                end
                if (req_cmd == `DDRSP_CMD_ACT) begin
                    act_cnt <= ACT_CK - 8'h01;
                end
                if (is_rd) begin
                    pre_cnt <= keep_max(pre_cnt, RTP_CK - 8'h01);
                end
                if (req_cmd == `DDRSP_CMD_WR || req_cmd == `DDRSP_CMD_WRA) begin
                    mem_dqs_start <= 1'b1;
                    rd_cnt <= keep_max(rd_cnt, (grade_533 ? WTR5_CK : WTR4_CK) + COL_CK);
                end
                if (req_cmd == `DDRSP_CMD_WRA) begin
                    case (req_bank)
                        2'h0: bank_cnt0 <= DAL_CK + COL_CK;
                        2'h1: bank_cnt1 <= DAL_CK + COL_CK;
                        2'h2: bank_cnt2 <= DAL_CK + COL_CK;
                        default: bank_cnt3 <= DAL_CK + COL_CK;
                    endcase
                end
                if (req_cmd == `DDRSP_CMD_MRS) begin
                    nonrd_cnt <= keep_max(nonrd_cnt, MRD_CK - 8'h01);
                    rd_cnt <= keep_max(rd_cnt, MRD_CK - 8'h01);
                    term_cnt <= keep_max(term_cnt, keep_max(MOD_CK, OIT_CK));
                end
            end
            if (state == S_ACTIVE && next_state == S_TERM) begin
                term_cnt <= ANPD_CK;
            end
            if (state == S_TERM && next_state != S_TERM && next_state != S_ACTIVE) begin
                mem_cke <= 1'b0;
                cke_cnt <= CKE_CK - 8'h01;
                clk_cnt <= HOLD_CK;
            end
            if ((state == S_PD || state == S_SR) && next_state == S_ACTIVE) begin
                mem_cke <= 1'b1;
                mem_clk_en <= 1'b1;
                cke_cnt <= CKE_CK - 8'h01;
                term_cnt <= AXPD_CK;
                if (state == S_SR) begin
                    nonrd_cnt <= XSNR_CK;
                    rd_cnt <= XSRD_CK;
                end else begin
                    nonrd_cnt <= XP_CK;
                    rd_cnt <= slow_exit ? slow_ck : XARD_CK;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/ddrsp_guard_props.sv
// Port checker for the command spacing guard
// Bound to ddrsp_guard; single ref_clk domain, rst_n active low
`timescale 1ns/1ps
`default_nettype none
`include "ddrsp_defines.vh"
module ddrsp_guard_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] mem_cmd,
    input wire logic [1:0] mem_bank,
    input wire logic mem_cke,
    input wire logic mem_odt,
    input wire logic mem_clk_en,
    input wire logic mem_dqs_start,
    input wire logic term_valid
);
    logic col;
    logic seen_pd;
    assign col = mem_cmd == `DDRSP_CMD_RD || mem_cmd == `DDRSP_CMD_WR || mem_cmd == `DDRSP_CMD_WRA;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Marks a clock enable drop seen since reset
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_pd <= 1'b0;
        end else if ($fell(mem_cke)) begin
            seen_pd <= 1'b1;
        end
    end
    property p_col; col |=> !col; endproperty
    a_col: assert property (p_col) else $error("column commands too close");
    property p_mrs; mem_cmd == `DDRSP_CMD_MRS |=> mem_cmd == `DDRSP_CMD_NOP; endproperty
    a_mrs: assert property (p_mrs) else $error("command right after mode load");
    property p_wtr; mem_cmd == `DDRSP_CMD_WR |=> (mem_cmd != `DDRSP_CMD_RD) [*2]; endproperty
    a_wtr: assert property (p_wtr) else $error("read too soon after write");
    property p_dal;
        mem_cmd == `DDRSP_CMD_ACT |->
            !(($past(mem_cmd, 1) == `DDRSP_CMD_WRA && $past(mem_bank, 1) == mem_bank)
            || ($past(mem_cmd, 2) == `DDRSP_CMD_WRA && $past(mem_bank, 2) == mem_bank)
            || ($past(mem_cmd, 3) == `DDRSP_CMD_WRA && $past(mem_bank, 3) == mem_bank));
    endproperty
    a_dal: assert property (p_dal) else $error("activate in auto precharge window");
    property p_ckeh; $rose(mem_cke) |=> mem_cke [*2]; endproperty
    a_ckeh: assert property (p_ckeh) else $error("clock enable high too short");
    property p_ckel; $fell(mem_cke) |=> !mem_cke [*2]; endproperty
    a_ckel: assert property (p_ckel) else $error("clock enable low too short");
    property p_clk; $fell(mem_cke) |-> mem_clk_en ##1 mem_clk_en; endproperty
    a_clk: assert property (p_clk) else $error("clock stopped after enable drop");
    property p_dqs;
        mem_dqs_start == (mem_cmd == `DDRSP_CMD_WR || mem_cmd == `DDRSP_CMD_WRA);
    endproperty
    a_dqs: assert property (p_dqs) else $error("strobe start not with write");
    property p_xp;
        mem_cmd != `DDRSP_CMD_NOP && mem_cmd != `DDRSP_CMD_REF |->
            mem_cke && $past(mem_cke, 1) && $past(mem_cke, 2);
    endproperty
    a_xp: assert property (p_xp) else $error("command too soon after exit");
    property p_tv; $rose(mem_cke) && seen_pd |-> !term_valid [*8]; endproperty
    a_tv: assert property (p_tv) else $error("termination trusted too early");
    property p_odt;
        $fell(mem_cke) |-> $stable(mem_odt) && $past(mem_odt, 1) == $past(mem_odt, 2);
    endproperty
    a_odt: assert property (p_odt) else $error("termination moved before entry");
endmodule
bind ddrsp_guard ddrsp_guard_props ddrsp_guard_props_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .mem_cmd(mem_cmd), .mem_bank(mem_bank), .mem_cke(mem_cke), .mem_odt(mem_odt),
    .mem_clk_en(mem_clk_en), .mem_dqs_start(mem_dqs_start), .term_valid(term_valid));
`default_nettype wire

// ===== testbench/ddrsp_mem_model.sv
// Behavioural memory device seen from its command pins
// Assumes the memory clock equals ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "ddrsp_defines.vh"
module ddrsp_mem_model #(
    parameter integer BANK_IDLE_CK = 1,
    parameter integer TERM_UPDATE_CK = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] mem_cmd,
    input wire logic [1:0] mem_bank,
    input wire logic mem_odt,
    input wire logic mem_clk_en,
    output var integer viol,
    output var logic term_applied
);
    integer busy [0:3];
    integer term_cnt;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            viol <= 0;
            term_applied <= 1'b0;
            term_cnt <= 0;
            for (int i = 0; i < 4; i++) busy[i] <= 0;
        end else begin
            for (int i = 0; i < 4; i++) if (busy[i] > 0) busy[i] <= busy[i] - 1;
            if (mem_cmd == `DDRSP_CMD_WRA) busy[mem_bank] <= BANK_IDLE_CK;
            if (mem_cmd == `DDRSP_CMD_ACT && busy[mem_bank] > 0) viol <= viol + 1;
            if (mem_cmd != `DDRSP_CMD_NOP && !mem_clk_en) viol <= viol + 1;
            if (mem_cmd == `DDRSP_CMD_MRS) term_cnt <= TERM_UPDATE_CK;
            else if (term_cnt > 0) term_cnt <= term_cnt - 1;
            if (term_cnt == 1) term_applied <= mem_odt;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_ddr2_command_spacing_rules.sv
// Self-checking bench for the command spacing guard
// Assumes ddrsp_guard, ddrsp_mem_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "ddrsp_defines.vh"
module tb_ddr2_command_spacing_rules;
    logic ref_clk, rst_n, req_valid, grade_533, pd_req, selfrefresh_req, slow_exit, term_req;
    logic [2:0] req_cmd, additive_latency;
    logic [1:0] req_bank;
    wire req_ready, mem_cke, mem_odt, mem_clk_en, mem_dqs_start, term_valid;
    wire [2:0] mem_cmd;
    wire [1:0] mem_bank;
    integer viol, n_errors, check_count, cyc, rise_t, tv_t;
    integer stamp [0:7];
    integer prev [0:7];
    logic term_applied, cke_d, tv_d;
    ddrsp_guard ddrsp_guard_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bank(req_bank), .grade_533(grade_533),
        .additive_latency(additive_latency), .pd_req(pd_req), .selfrefresh_req(selfrefresh_req),
        .slow_exit(slow_exit), .term_req(term_req), .req_ready(req_ready), .mem_cmd(mem_cmd),
        .mem_bank(mem_bank), .mem_cke(mem_cke), .mem_odt(mem_odt), .mem_clk_en(mem_clk_en),
        .mem_dqs_start(mem_dqs_start), .term_valid(term_valid));
    ddrsp_mem_model #(.BANK_IDLE_CK(3), .TERM_UPDATE_CK(1)) ddrsp_mem_model_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .mem_cmd(mem_cmd),
        .mem_bank(mem_bank), .mem_odt(mem_odt), .mem_clk_en(mem_clk_en), .viol(viol),
        .term_applied(term_applied));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Cycle stamps of commands, clock enable rise and termination trust
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        cke_d <= mem_cke;
        tv_d <= term_valid;
        if (mem_cmd != `DDRSP_CMD_NOP) begin
            stamp[mem_cmd] <= cyc;
            prev[mem_cmd] <= stamp[mem_cmd];
        end
        if (mem_cke === 1'b1 && cke_d !== 1'b1) rise_t <= cyc;
        if (term_valid === 1'b1 && tv_d !== 1'b1) tv_t <= cyc;
    end
    task automatic test_done;
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_ge(input string nm, input integer mn, input integer seen);
        check_count = check_count + 1;
        if (seen < mn) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s expected >= %0d seen %0d", nm, mn, seen);
        end
    endtask
    task automatic chk_bit(input string nm, input logic exp, input logic seen);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    task automatic wait_for(input logic v, input logic is_cke);
        integer k;
        k = 0;
        @(negedge ref_clk);
        while ((is_cke ? mem_cke : req_ready) !== v) begin
            k = k + 1;
            if (k > 600) begin
                n_errors = n_errors + 1;
                test_done;
            end
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask
    task automatic issue(input logic [2:0] c, input logic [1:0] b);
        req_cmd <= c;
        req_bank <= b;
        req_valid <= 1'b1;
        wait_for(1'b1, 1'b0);
    endtask
    task automatic gap(input string nm, input logic [2:0] a, input logic [2:0] c, input integer mn);
        issue(a, 2'h1);
        issue(c, 2'h1);
        req_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_ge(nm, mn, stamp[c] - ((a == c) ? prev[c] : stamp[a]));
    endtask
    task automatic t_spacing;
        term_req <= 1'b1;
        gap("act_to_act_gap", `DDRSP_CMD_ACT, `DDRSP_CMD_ACT, 1);
        gap("column_cmd_gap", `DDRSP_CMD_RD, `DDRSP_CMD_RD, 2);
        gap("column_cmd_gap", `DDRSP_CMD_WR, `DDRSP_CMD_WR, 2);
        gap("autoprecharge_write_gap", `DDRSP_CMD_WRA, `DDRSP_CMD_ACT, 4);
        gap("read_to_precharge_gap", `DDRSP_CMD_RD, `DDRSP_CMD_PRE, 1);
        gap("mode_load_cycle_gap", `DDRSP_CMD_MRS, `DDRSP_CMD_MRS, 2);
        gap("mode_load_cycle_gap", `DDRSP_CMD_MRS, `DDRSP_CMD_ACT, 2);
        chk_bit("term_applied", 1'b1, term_applied);
        for (int g = 0; g < 2; g++) begin
            grade_533 <= g[0];
            gap("write_to_read_gap", `DDRSP_CMD_WR, `DDRSP_CMD_RD, 3);
        end
    endtask
    // Enter power down or self refresh, leave, then time the first command
    task automatic t_low(input logic sr, input logic [2:0] c, input logic slow,
        input logic [2:0] al, input integer mn);
        term_req <= ~term_req;
        pd_req <= ~sr;
        selfrefresh_req <= sr;
        slow_exit <= slow;
        additive_latency <= al;
        wait_for(1'b0, 1'b1);
        chk_bit("mem_odt", term_req, mem_odt);
        repeat (4) @(posedge ref_clk);
        pd_req <= 1'b0;
        selfrefresh_req <= 1'b0;
        wait_for(1'b1, 1'b1);
        issue(c, 2'h0);
        req_valid <= 1'b0;
        repeat (12) @(posedge ref_clk);
        chk_ge("exit_gap", mn, stamp[c] - rise_t);
        if (!sr) chk_ge("termination_pd_exit_latency", 8, tv_t - rise_t);
    endtask
    initial begin
        {rst_n, req_valid, grade_533, pd_req, selfrefresh_req, slow_exit, term_req} = 7'h00;
        req_cmd = 3'h0;
        req_bank = 2'h0;
        additive_latency = 3'h0;
        {n_errors, check_count, cyc, rise_t, tv_t} = 0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_spacing;
        t_low(1'b0, `DDRSP_CMD_RD, 1'b0, 3'h0, 2);
        t_low(1'b0, `DDRSP_CMD_RD, 1'b1, 3'h2, 4);
        t_low(1'b0, `DDRSP_CMD_RD, 1'b1, 3'h0, 6);
        t_low(1'b0, `DDRSP_CMD_PRE, 1'b0, 3'h0, 2);
        t_low(1'b1, `DDRSP_CMD_ACT, 1'b0, 3'h0, 2);
        t_low(1'b1, `DDRSP_CMD_RD, 1'b0, 3'h0, 200);
        chk_bit("model_viol", 1'b1, viol == 0);
        test_done;
    end
endmodule
`default_nettype wire
